// *** core/power_ctrl_config_status_regs.sv ***
// Serial configuration and status register of the power controller.
`timescale 1ns/1ns
`default_nettype none
`include "power_ctrl_params.svh"

module power_ctrl_config_status_regs #(
  parameter int WORD_BITS  = `PC_WORD_BITS,
  parameter int QUICK_BITS = `PC_QUICK_BITS
) (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        serial_clk,
  input  wire logic                        chip_enable,
  input  wire logic                        serial_data_in,
  output logic                             serial_data_out,
  input  wire logic                        shutdown_pin_n,
  input  wire logic                        battery_cmp_in,
  input  wire logic                        rail33_fault_cmp_in,
  input  wire logic                        charger_cmp_in,
  input  wire logic                        undervoltage_lockout_ok,
  input  wire logic                        ext5_supply_present,
  input  wire logic                        rail5_good,
  output logic                             interrupt_out,
  output logic                             opendrain_out,
  output logic                             opendrain_out_oe_n,
  output power_ctrl_pkg::analog_ctrl_t     analog_ctrl
);
  import power_ctrl_pkg::*;

  // The frame counter and the field layout are built for these sizes only.
  initial begin
    if (WORD_BITS != 32 || QUICK_BITS != 8 || QUICK_BITS >= WORD_BITS) begin
      $error("power_ctrl_config_status_regs: unsupported word or quick-access size");
    end
  end

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_FULL  = CNT_W'(WORD_BITS);
  localparam logic [CNT_W-1:0] CNT_QUICK = CNT_W'(QUICK_BITS);
  localparam logic [CNT_W-1:0] CNT_STAT  = CNT_W'(`PC_STATUS_BITS);
  localparam logic [CNT_W-1:0] CNT_SAT   = CNT_W'(WORD_BITS + 1);

  // Input indices into the synchroniser bank.
  localparam int IN_CE   = 0;
  localparam int IN_SHUTDOWN_PIN = 1;
  localparam int IN_BATT = 2;
  localparam int IN_R33  = 3;
  localparam int IN_CHG  = 4;
  localparam int IN_UNDERVOLTAGE_LOCKOUT_IN = 5;
  localparam int IN_EXT5 = 6;
  localparam int IN_R5OK = 7;
  localparam int IN_N    = 8;

  // Picks the status bit for the given serial position, first bit first.
  function automatic logic status_bit(input logic [5:0] snap, input logic [CNT_W-1:0] pos);
    logic [2:0] idx;
    idx = 3'(CNT_STAT - 6'd1 - pos);
    return (pos < CNT_STAT) ? snap[idx] : 1'b0;
  endfunction : status_bit

  // ---------------------------------------------------------------- link domain
  logic                 link_clear_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [CNT_W-1:0]     bit_cnt_q;
  logic [5:0]           status_snap_q;

  // Shift register on the link clock; it sits still between frames, so the
  // system side may read it once chip-enable has dropped and before it clears it.
  always_ff @(posedge serial_clk or posedge link_clear_q) begin
    if (link_clear_q) begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
    end else if (chip_enable) begin
      shift_q   <= {shift_q[WORD_BITS-2:0], serial_data_in};
      bit_cnt_q <= (bit_cnt_q == CNT_SAT) ? CNT_SAT : bit_cnt_q + 6'd1;
    end
  end

  // The snapshot is frozen for the whole frame, so reading it here is safe.
  assign serial_data_out = chip_enable & status_bit(status_snap_q, bit_cnt_q);

  // ---------------------------------------------------------------- system domain
  logic [IN_N-1:0] in_raw;
  logic [IN_N-1:0] sync1_q;
  logic [IN_N-1:0] sync2_q;
  logic [IN_N-1:0] sync3_q;
  logic [IN_N-1:0] filt_q;
  logic [IN_N-1:0] filt_d;

  assign in_raw = {rail5_good, ext5_supply_present, undervoltage_lockout_ok, charger_cmp_in,
                   rail33_fault_cmp_in, battery_cmp_in, shutdown_pin_n, chip_enable};

  // Three-stage synchroniser; a level is taken once the last two stages agree.
  assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
    end else begin
      sync1_q <= in_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  config_word_t cfg_q;
  config_word_t cfg_d;
  config_word_t frame_word;
  logic [2:0]   init_q;
  logic [2:0]   init_d;
  logic         ready;
  logic         ce_prev_q;
  logic         frame_end;
  logic         full_frame;
  logic         quick_frame;
  op_mode_t     mode_d;
  logic         supply_lost;

  assign ready       = (init_q == `PC_INIT_CYCLES);
  assign frame_end   = ready & ce_prev_q & ~filt_q[IN_CE];
  assign frame_word  = config_word_t'(shift_q);
  assign full_frame  = frame_end & (bit_cnt_q == CNT_FULL);
  assign quick_frame = frame_end & (bit_cnt_q == CNT_QUICK) & (shift_q[7:0] != 8'h00);

  // Internal 5V collapses when its regulator is off with no outside supply.
  assign supply_lost = ready & ((~cfg_q.aux5_regulator_enable & ~filt_q[IN_EXT5])
                                | ~filt_q[IN_R5OK]);

  // Mode selection from shutdown pin, mode bits and chip-enable.
  always_comb begin
    if (!filt_q[IN_SHUTDOWN_PIN]) begin
      mode_d = MODE_SHUTDOWN;
    end else begin
      case ({cfg_q.op_mode_sel_hi, cfg_q.op_mode_sel_lo})
        2'b11:   mode_d = filt_q[IN_CE] ? MODE_OPERATE : MODE_LOW_POWER;
        2'b01:   mode_d = filt_q[IN_CE] ? MODE_STANDBY : MODE_LOW_POWER;
        2'b00:   mode_d = MODE_STANDBY;
        2'b10:   mode_d = MODE_OPERATE;
        default: mode_d = MODE_LOW_POWER;
      endcase
    end
  end

  // Status comparators, each forced low in the modes that switch it off.
  logic batt_stat;
  logic r33_stat;
  logic chg_stat;

  assign batt_stat = filt_q[IN_BATT] & (mode_d == MODE_STANDBY || mode_d == MODE_OPERATE);
  assign r33_stat  = filt_q[IN_R33] & (mode_d == MODE_OPERATE);
  assign chg_stat  = filt_q[IN_CHG] & (mode_d != MODE_SHUTDOWN);

  // Configuration: full frames load bits 24..0, quick frames only the low byte.
  always_comb begin
    cfg_d = cfg_q;
    if (!ready) begin
      cfg_d = config_word_t'(`PC_CFG_RESET);
    end else if (full_frame) begin
      cfg_d = config_word_t'(shift_q & `PC_CFG_WR_MASK);
    end else if (quick_frame) begin
      cfg_d = config_word_t'({cfg_q[WORD_BITS-1:8], shift_q[7:0]});
    end
  end

  // Power-up wait lets the synchronisers fill before anything is judged.
  assign init_d = supply_lost ? 3'h0 : (ready ? init_q : init_q + 3'h1);

  // Sticky flags and status edge detection.
  logic [2:0] stat_prev_q;
  logic [2:0] irq_q;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [2:0] irq_d;
  logic       powerup;

  assign powerup    = (init_q == `PC_INIT_CYCLES - 3'h1);
  assign irq_set[2] = (ready & (batt_stat ^ stat_prev_q[2]))
                      | (powerup & ~filt_q[IN_CHG]);
  assign irq_set[1] = ready & r33_stat & ~stat_prev_q[1];
  assign irq_set[0] = (ready & (chg_stat ^ stat_prev_q[0]))
                      | (powerup & filt_q[IN_CHG]);
  assign irq_clr    = full_frame ? {frame_word.battery_irq_flag,
                                    frame_word.rail33_fault_irq_flag,
                                    frame_word.charger_irq_flag} : 3'h0;
  // A status change landing with its clear still sets the flag.
  assign irq_d      = (ready | powerup) ? ((irq_q & ~irq_clr) | irq_set) : 3'h0;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      init_q       <= 3'h0;
      cfg_q        <= config_word_t'(`PC_CFG_RESET);
      irq_q        <= 3'h0;
      stat_prev_q  <= 3'h0;
      ce_prev_q    <= 1'b0;
    end else begin
      init_q       <= init_d;
      cfg_q        <= cfg_d;
      irq_q        <= irq_d;
      stat_prev_q  <= {batt_stat, r33_stat, chg_stat};
      ce_prev_q    <= filt_q[IN_CE];
    end
  end

  // Link clear holds the shifter idle whenever chip-enable is seen low; it is
  // raised the edge after a frame ends, so the frame is taken first.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      link_clear_q <= 1'b1;
    end else begin
      link_clear_q <= ~filt_q[IN_CE];
    end
  end

  // Status snapshot, refreshed only outside frames so the link sees a stable word.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_snap_q <= 6'h00;
    end else if (!filt_q[IN_CE]) begin
      status_snap_q <= {irq_q[2], batt_stat, irq_q[1], r33_stat, irq_q[0], chg_stat};
    end
  end

  // Registered controls for the analog sections.
  analog_ctrl_t ctrl_d;
  logic         active;
  logic         operate;

  assign operate = (mode_d == MODE_OPERATE);
  assign active  = operate | (mode_d == MODE_STANDBY);

  always_comb begin
    ctrl_d                       = '0;
    ctrl_d.mode                  = mode_d;
    ctrl_d.gate_drive_source     = operate ? cfg_q.gate_drive_select : 5'h00;
    ctrl_d.analog_sel            = cfg_q.analog_sel;
    ctrl_d.analog_mux_enable     = active;
    ctrl_d.charge_code           = cfg_q.charge_code;
    ctrl_d.aux5_regulator_enable = cfg_q.aux5_regulator_enable;
    ctrl_d.buck_enable           = operate & filt_q[IN_UNDERVOLTAGE_LOCKOUT_IN];
    ctrl_d.charger_source_enable = cfg_q.charger_enable & active & filt_q[IN_UNDERVOLTAGE_LOCKOUT_IN];
    ctrl_d.linear33_enable       = (mode_d != MODE_SHUTDOWN) & ~ctrl_d.buck_enable;
    ctrl_d.idle_regulation       = cfg_q.idle_regulation;
    ctrl_d.prog_volt_enable      = operate;
    ctrl_d.prog_volt_a_sel       = cfg_q.prog_volt_a_sel;
    ctrl_d.prog_volt_b_sel       = cfg_q.prog_volt_b_sel;
  end

  logic irq_out_q;
  logic od_sink_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      analog_ctrl <= '0;
      irq_out_q   <= 1'b0;
      od_sink_q   <= 1'b0;
    end else begin
      analog_ctrl <= ctrl_d;
      irq_out_q   <= |irq_d;
      od_sink_q   <= cfg_d.opendrain_out_sink;
    end
  end

  // Open-drain pin only ever pulls low; enable is active low while sinking.
  assign interrupt_out      = irq_out_q;
  assign opendrain_out      = 1'b0;
  assign opendrain_out_oe_n = ~od_sink_q;

endmodule : power_ctrl_config_status_regs
`default_nettype wire

// *** shared/power_ctrl_params.svh ***
// Constants of the serial configuration and status word of the power controller.
//
// Operation
// - Each 32-bit transfer returns 32 bits; only the first six carry status.
// - Battery-present status bit 30 is 1 when thermistor input is high.
// - Any change of battery-present status sets sticky flag bit 31.
// - Writing 1 into bit 31 clears the battery flag.
// - Battery-present status reads 0 in low-power and shutdown modes.
// - Rail fault status bit 28 is 1 while the 3.3V rail is out of regulation.
// - Only a rising rail fault status sets sticky flag bit 29.
// - Rail fault status reads 0 in low-power, standby and shutdown modes.
// - Charger-present status bit 26 is 1 when charger exceeds battery.
// - Any change of charger-present status sets sticky flag bit 27.
// - Charger-present comparator is disabled only in shutdown mode.
// - At power-up set battery flag without charger, charger flag with charger.
// - Interrupt pin is the OR of the three sticky flags.
// - Reset sets bits 20, 18, 11, 9, 7, 6, 5, 4; others are 0.
// - Bits 24..20 choose source (1) or sink (0) for five gate drivers.
// - Bits 19..17 select the analog mux channel, bit 19 most significant.
// - Bits 16..10 form the charger current code, bit 16 most significant.
// - Bit 9 enables the 5V regulator; bit 8 makes open-drain output sink.
// - Bit 7 enables charger source; bit 6 picks pulse-skipping over PWM.
// - Bits 5..4 select mode; bits 3..2 and 1..0 select programming voltages.
// - Loss of the internal 5V supply restores every power-on default.
// - Undervoltage lockout holds buck and charger off, even in operate mode.
// - Host shifts the word in most significant bit first while enabled.
// - An 8-clock access updates only the low byte and still returns status.
// - An 8-clock access of all zeros changes no configuration.
// - Mode follows shutdown pin, mode bits and chip-enable as tabulated.
`ifndef POWER_CTRL_PARAMS_SVH
`define POWER_CTRL_PARAMS_SVH

`define PC_WORD_BITS      32
`define PC_QUICK_BITS     8
`define PC_STATUS_BITS    6
`define PC_BIT_BATT_IRQ   31
`define PC_BIT_R33_IRQ    29
`define PC_BIT_CHG_IRQ    27
`define PC_CFG_RESET      32'h0014_0AF0
`define PC_CFG_WR_MASK    32'h01FF_FFFF
`define PC_INIT_CYCLES    3'h5

`endif

// *** shared/power_ctrl_pkg.sv ***
// Types shared by the power controller configuration and status logic.
package power_ctrl_pkg;

  // Operating modes of the controller.
  typedef enum logic [1:0] {
    MODE_SHUTDOWN  = 2'b00,
    MODE_LOW_POWER = 2'b01,
    MODE_STANDBY   = 2'b10,
    MODE_OPERATE   = 2'b11
  } op_mode_t;

  // The 32-bit word as laid out on the serial link.
  typedef struct packed {
    logic       battery_irq_flag;
    logic       battery_present_status;
    logic       rail33_fault_irq_flag;
    logic       rail33_fault_status;
    logic       charger_irq_flag;
    logic       charger_present_status;
    logic       unused_25;
    logic [4:0] gate_drive_select;
    logic [2:0] analog_sel;
    logic [6:0] charge_code;
    logic       aux5_regulator_enable;
    logic       opendrain_out_sink;
    logic       charger_enable;
    logic       idle_regulation;
    logic       op_mode_sel_hi;
    logic       op_mode_sel_lo;
    logic [1:0] prog_volt_b_sel;
    logic [1:0] prog_volt_a_sel;
  } config_word_t;

  // Controls presented to the analog sections.
  typedef struct packed {
    op_mode_t   mode;
    logic [4:0] gate_drive_source;
    logic [2:0] analog_sel;
    logic       analog_mux_enable;
    logic [6:0] charge_code;
    logic       aux5_regulator_enable;
    logic       charger_source_enable;
    logic       buck_enable;
    logic       linear33_enable;
    logic       idle_regulation;
    logic       prog_volt_enable;
    logic [1:0] prog_volt_a_sel;
    logic [1:0] prog_volt_b_sel;
  } analog_ctrl_t;

endpackage : power_ctrl_pkg

// *** sim/host_serial_model.sv ***
// Host-side serial master model for the power controller link.
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
  output logic      serial_clk,
  output logic      chip_enable,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  initial begin
    serial_clk     = 1'b0;
    chip_enable    = 1'b0;
    serial_data_in = 1'b1;
  end

  // One frame; the link clock runs only inside it and stands still between frames.
  task automatic xfer(input int nbits, input logic [31:0] word, output logic [5:0] status);
    status      = 6'h00;
    chip_enable = 1'b1;
    #400;
    for (int k = 0; k < nbits; k++) begin
      serial_data_in = word[nbits - 1 - k];
      #40;
      if (k < 6) status[5 - k] = serial_data_out;
      serial_clk = 1'b1;
      #40;
      serial_clk = 1'b0;
    end
    chip_enable    = 1'b0;
    // A released line shows the inverse so a stale bit cannot pass for data.
    serial_data_in = ~serial_data_in;
    #400;
  endtask : xfer
endmodule : host_serial_model
`default_nettype wire

// *** sim/power_ctrl_checker.sv ***
// Port-level checker for the power controller configuration and status block.
`timescale 1ns/1ns
`default_nettype none
module power_ctrl_checker
  import power_ctrl_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  input wire logic         chip_enable,
  input wire logic         serial_data_out,
  input wire logic         shutdown_pin_n,
  input wire logic         undervoltage_lockout_ok,
  input wire logic         opendrain_out,
  input wire analog_ctrl_t analog_ctrl
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Pin inputs pass a three-flop synchroniser, so held levels get six cycles before judging.
  dout_idle_a: assert property (!chip_enable |-> !serial_data_out)
    else $error("data out high outside a frame");
  od_level_a: assert property (opendrain_out == 1'b0)
    else $error("open-drain data not low");
  gate_off_a: assert property (analog_ctrl.mode != MODE_OPERATE |->
    analog_ctrl.gate_drive_source == 5'h00) else $error("gate driver sourcing outside operate");
  lockout_hold_a: assert property (!undervoltage_lockout_ok [*6] |=>
    !analog_ctrl.buck_enable && !analog_ctrl.charger_source_enable)
    else $error("buck or charger on under lockout");
  shutdown_force_a: assert property (!shutdown_pin_n [*6] |=>
    analog_ctrl.mode == MODE_SHUTDOWN) else $error("shutdown pin ignored");
  linear_path_a: assert property (analog_ctrl.linear33_enable ==
    (analog_ctrl.mode != MODE_SHUTDOWN && !analog_ctrl.buck_enable))
    else $error("linear path mismatch");
  mux_enable_a: assert property (analog_ctrl.analog_mux_enable == analog_ctrl.mode[1])
    else $error("mux enable mismatch");
  charger_mode_a: assert property (analog_ctrl.charger_source_enable |-> analog_ctrl.mode[1])
    else $error("charger on in wrong mode");
  prog_volt_a: assert property (
    analog_ctrl.prog_volt_enable == (analog_ctrl.mode == MODE_OPERATE))
    else $error("programming voltage enable mismatch");
endmodule : power_ctrl_checker

bind power_ctrl_config_status_regs power_ctrl_checker power_ctrl_checker_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .chip_enable(chip_enable),
  .serial_data_out(serial_data_out), .shutdown_pin_n(shutdown_pin_n),
  .undervoltage_lockout_ok(undervoltage_lockout_ok), .opendrain_out(opendrain_out),
  .analog_ctrl(analog_ctrl));
`default_nettype wire

// *** sim/power_ctrl_config_status_regs_tb.sv ***
// Self-checking bench for the power controller configuration and status block.
`timescale 1ns/1ns
`default_nettype none
module power_ctrl_config_status_regs_tb;
  import power_ctrl_pkg::*;
  logic         clk_sys, sys_rst, shutdown_pin_n, battery_cmp_in, rail33_fault_cmp_in;
  logic         charger_cmp_in, undervoltage_lockout_ok, ext5_supply_present, rail5_good;
  logic         serial_clk, chip_enable, serial_data_in, serial_data_out;
  logic         interrupt_out, opendrain_out, opendrain_out_oe_n;
  analog_ctrl_t analog_ctrl, exp_ctl;
  logic [5:0]   st;
  int           err_total, samples_checked, cycles;
  localparam analog_ctrl_t def_ctl = '{MODE_LOW_POWER, 5'h00, 3'h2, 1'b0, 7'h02, 1'b1,
                                       1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0};

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  power_ctrl_config_status_regs power_ctrl_config_status_regs_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .chip_enable(chip_enable), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .shutdown_pin_n(shutdown_pin_n),
    .battery_cmp_in(battery_cmp_in), .rail33_fault_cmp_in(rail33_fault_cmp_in),
    .charger_cmp_in(charger_cmp_in), .undervoltage_lockout_ok(undervoltage_lockout_ok),
    .ext5_supply_present(ext5_supply_present), .rail5_good(rail5_good),
    .interrupt_out(interrupt_out), .opendrain_out(opendrain_out),
    .opendrain_out_oe_n(opendrain_out_oe_n), .analog_ctrl(analog_ctrl));

  host_serial_model host_serial_model_inst (
    .serial_clk(serial_clk), .chip_enable(chip_enable),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic close_out;
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // Pins are synchronised and config lands a few cycles after a frame, so allow a margin.
  task automatic settle;
    repeat (12) @(posedge clk_sys);
  endtask : settle

  task automatic wr32(input logic [31:0] w);
    host_serial_model_inst.xfer(32, w, st);
    settle();
  endtask : wr32

  task automatic wr8(input logic [7:0] b);
    host_serial_model_inst.xfer(8, {24'h000000, b}, st);
    settle();
  endtask : wr8

  task automatic t_power_up;
    cmp({31'h0, interrupt_out}, 32'h1);
    wr32(32'h8014_0AF0);
    cmp({26'h0, st}, 32'h20);
    cmp({4'h0, analog_ctrl}, {4'h0, def_ctl});
    cmp({31'h0, interrupt_out}, 32'h0);
  endtask : t_power_up

  task automatic t_fields;
    wr32(32'h036B_67A7);
    exp_ctl = '{MODE_OPERATE, 5'h16, 3'h5, 1'b1, 7'h59, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1,
                2'h3, 2'h1};
    cmp({4'h0, analog_ctrl}, {4'h0, exp_ctl});
    cmp({31'h0, opendrain_out_oe_n}, 32'h0);
    @(posedge clk_sys) undervoltage_lockout_ok <= 1'b0;
    settle();
    exp_ctl.buck_enable = 1'b0;
    exp_ctl.charger_source_enable = 1'b0;
    exp_ctl.linear33_enable = 1'b1;
    cmp({4'h0, analog_ctrl}, {4'h0, exp_ctl});
    @(posedge clk_sys) undervoltage_lockout_ok <= 1'b1;
    settle();
  endtask : t_fields

  task automatic t_quick;
    wr8(8'h31);
    exp_ctl = '{MODE_LOW_POWER, 5'h00, 3'h5, 1'b0, 7'h59, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
                2'h1, 2'h0};
    cmp({4'h0, analog_ctrl}, {4'h0, exp_ctl});
    wr8(8'h00);
    cmp({4'h0, analog_ctrl}, {4'h0, exp_ctl});
  endtask : t_quick

  task automatic t_events;
    wr8(8'hA7);
    @(posedge clk_sys) battery_cmp_in <= 1'b1;
    @(posedge clk_sys) rail33_fault_cmp_in <= 1'b1;
    @(posedge clk_sys) charger_cmp_in <= 1'b1;
    settle();
    cmp({31'h0, interrupt_out}, 32'h1);
    wr8(8'hA7);
    cmp({26'h0, st}, 32'h3F);
    wr32(32'hAB6B_67A7);
    cmp({31'h0, interrupt_out}, 32'h0);
    @(posedge clk_sys) rail33_fault_cmp_in <= 1'b0;
    settle();
    cmp({31'h0, interrupt_out}, 32'h0);
    @(posedge clk_sys) charger_cmp_in <= 1'b0;
    settle();
    wr8(8'hA7);
    cmp({26'h0, st}, 32'h12);
  endtask : t_events

  task automatic t_modes;
    wr8(8'h87);
    cmp({30'h0, analog_ctrl.mode}, {30'h0, MODE_STANDBY});
    // A rail fault in standby must stay invisible and raise no flag.
    @(posedge clk_sys) rail33_fault_cmp_in <= 1'b1;
    settle();
    wr8(8'h00);
    cmp({26'h0, st}, 32'h12);
    @(posedge clk_sys) begin
      shutdown_pin_n      <= 1'b0;
      rail33_fault_cmp_in <= 1'b0;
    end
    settle();
    cmp({30'h0, analog_ctrl.mode}, {30'h0, MODE_SHUTDOWN});
    @(posedge clk_sys) shutdown_pin_n <= 1'b1;
    settle();
    wr8(8'h97);
    cmp({30'h0, analog_ctrl.mode}, {30'h0, MODE_LOW_POWER});
  endtask : t_modes

  task automatic t_soft;
    @(posedge clk_sys) ext5_supply_present <= 1'b0;
    wr32(32'h0014_08F0);
    cmp({4'h0, analog_ctrl}, {4'h0, def_ctl});
    cmp({31'h0, interrupt_out}, 32'h1);
    @(posedge clk_sys) ext5_supply_present <= 1'b1;
    // A second power-up with the charger present must flag the charger, not the battery.
    @(posedge clk_sys) begin
      charger_cmp_in <= 1'b1;
      sys_rst        <= 1'b1;
    end
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    cmp({4'h0, analog_ctrl}, {4'h0, def_ctl});
    wr8(8'h00);
    cmp({26'h0, st}, 32'h03);
  endtask : t_soft

  // A hang is cut short and counted as a mismatch.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    sys_rst = 1'b1;
    shutdown_pin_n = 1'b1;
    battery_cmp_in = 1'b0;
    rail33_fault_cmp_in = 1'b0;
    charger_cmp_in = 1'b0;
    undervoltage_lockout_ok = 1'b1;
    ext5_supply_present = 1'b1;
    rail5_good = 1'b1;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    t_power_up();
    t_fields();
    t_quick();
    t_events();
    t_modes();
    t_soft();
    close_out();
  end
endmodule : power_ctrl_config_status_regs_tb
`default_nettype wire
